// File: src/pgc_global_cfg.sv
/*
  Port global configuration block: global config, direction, input
  debounce and drive-current registers, timeout interrupt, shutdown
  control, soft reset of the port registers and the common fade ramp.
  Assumes the serial-bus engine presents byte accesses as single-cycle
  strobes synchronous to clk_i, and that key_sleep_i mirrors the
  key-switch sleep bit.
  Port registers from 0x44 up are cleared by the port_regs_reset_o pulse.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pgc_params.svh"

module pgc_global_cfg
  import pgc_pkg::*;
#(
  parameter int NPORT = 8,
  parameter int MS_CYC = `PGC_CLK_KHZ,
  parameter int FADE_UNIT_CYC = `PGC_FADE_BASE_MS * (`PGC_CLK_KHZ / `PGC_FADE_STEPS)
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic bus_timeout_i,
  input wire logic key_sleep_i,
  input wire logic fade_on_i,
  input wire logic [7:0] common_pwm_i,
  input wire logic [NPORT-1:0] port_pins_i,
  output logic port_interrupt_out_o,
  output logic upper_pin_pair_rotary_o,
  output logic [NPORT-1:0] port_dir_o,
  output logic [NPORT-1:0] general_inputs_o,
  output logic [1:0] drive_sel_o,
  output logic ports_shutdown_o,
  output logic device_shutdown_o,
  output logic port_regs_reset_o,
  output logic [7:0] fade_duty_o
);

  // refuse settings the counters cannot hold
  // stopping at elaboration beats letting a short counter wrap in silence
  if (NPORT != 8 || MS_CYC < 1 || FADE_UNIT_CYC < 1 ||
      FADE_UNIT_CYC > 32'h07ff_ffff) begin : g_bad_params
    $error("pgc_global_cfg: unsupported parameter values");
  end

  // address match helper, used by the write and read decoders
  // keeps every decoder comparing the full 8-bit offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // host-visible storage; port registers from 0x44 up live elsewhere
  logic [7:0] glob_q; // global config, bit 3 never stored
  logic [7:0] dir_q; // port direction
  logic [4:0] deb_q; // debounce code, upper bits read zero
  logic [7:0] drv_q; // drive-current register
  logic tmo_flag_q; // bus timeout seen, not yet read
  // output flops, so every port leaves the block straight from a register
  logic [7:0] rdata_q; // read data, held between reads
  logic soft_rst_q; // port register reset pulse
  logic irq_q; // interrupt level
  logic shut_q; // port section off
  logic dev_shut_q; // whole device off

  // section enable, bit 4 of the global register
  wire logic enabled = glob_q[`PGC_BIT_ENABLE];
  // a write to 0x40 lands whatever the enable state
  wire logic wr_glob = wr_en_i && hit(addr_i, `PGC_OFF_GLOBAL);
  wire logic soft_rst = wr_glob && wdata_i[`PGC_BIT_SOFT_RST];
  // frozen registers ignore writes while the section is off
  wire logic wr_open = wr_en_i && enabled && !soft_rst;
  // a read of the flag register clears it unless a timeout arrives in the same cycle
  wire logic rd_flag = rd_en_i && hit(addr_i, `PGC_OFF_TIMEOUT_FLAG);

  // global config; a set soft-reset bit clears the whole register
  // bit 3 is momentary: it triggers the reset and is never kept
  // reserved bit 6 is forced low so it always reads back zero
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_rst) begin
      glob_q <= `PGC_RST_GLOBAL;
    end else if (wr_glob) begin
      glob_q <= {wdata_i[7], 1'b0, wdata_i[5:4], 1'b0, wdata_i[2:0]};
    end
  end

  // direction, debounce and drive registers
  // soft reset outranks a same-cycle write, so nothing half-lands
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_rst) begin
      dir_q <= `PGC_RST_DIR;
      deb_q <= `PGC_RST_DEBOUNCE;
      drv_q <= `PGC_RST_DRIVE;
    end else if (wr_open) begin
      // bit n steers port n
      if (hit(addr_i, `PGC_OFF_DIR)) begin
        dir_q <= wdata_i;
      end
      // only the five code bits are kept; the rest read zero
      if (hit(addr_i, `PGC_OFF_DEBOUNCE)) begin
        deb_q <= wdata_i[4:0];
      end
      // reserved bits stored as written; the host keeps them at 11/0000
      if (hit(addr_i, `PGC_OFF_DRIVE)) begin
        drv_q <= wdata_i;
      end
    end
  end

  // timeout flag: a new timeout beats the clearing read
  // so a timeout racing the read is never lost; only one flag bit is kept
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tmo_flag_q <= 1'b0;
    end else if (bus_timeout_i) begin
      tmo_flag_q <= 1'b1;
    end else if (rd_flag) begin
      tmo_flag_q <= 1'b0;
    end
  end

  // registered read data, one cycle after the strobe
  // holds until the next read; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
    end else if (rd_en_i) begin
      case (addr_i)
        `PGC_OFF_GLOBAL: rdata_q <= glob_q;
        `PGC_OFF_DIR: rdata_q <= dir_q;
        `PGC_OFF_DEBOUNCE: rdata_q <= {3'h0, deb_q};
        `PGC_OFF_DRIVE: rdata_q <= drv_q;
        // the timeout flag reads back in bit 0
        `PGC_OFF_TIMEOUT_FLAG: rdata_q <= {7'h00, tmo_flag_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // status outputs, all registered
  // shutdown flags trail the enable bit by a cycle, the price of flop outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      soft_rst_q <= 1'b0;
      irq_q <= 1'b0;
      shut_q <= 1'b1;
      dev_shut_q <= 1'b0;
    end else begin
      // one-cycle pulse clears the port registers held outside this block
      soft_rst_q <= soft_rst;
      // interrupt follows the flag only while the timeout interrupt enable bit is set; a timeout in the
      // clearing read cycle keeps it up, matching the flag
      irq_q <= glob_q[`PGC_BIT_TMO_IE] && (bus_timeout_i || (tmo_flag_q && !rd_flag));
      shut_q <= !enabled;
      // key sleep only matters once the section is off
      dev_shut_q <= !enabled && key_sleep_i;
    end
  end

  // per-port debounce: ms tick shared, count per port
  // one shared prescaler saves a wide counter per port; the free-running
  // tick phase means a change may land up to one millisecond early
  logic [31:0] ms_cnt_q;
  wire logic ms_tick = (ms_cnt_q == 32'(MS_CYC - 1));
  wire logic [5:0] deb_limit = 6'(`PGC_DEB_BASE_MS) + {1'b0, deb_q};

  // prescaler restarts on its own tick
  always_ff @(posedge clk_i) begin
    if (srst_i || ms_tick) begin
      ms_cnt_q <= 32'h0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h1;
    end
  end

  logic [NPORT-1:0] gin_q;
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_deb
      logic [5:0] cnt_q;
      // restart the count whenever the pin agrees with the held level
      // outputs and a shut section keep the last debounced level
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          cnt_q <= 6'h00;
          gin_q[g] <= 1'b0;
        end else if (!enabled || dir_q[g]) begin
          cnt_q <= 6'h00; // inputs off or port is output: hold
        end else if (port_pins_i[g] == gin_q[g]) begin
          cnt_q <= 6'h00;
        end else if (ms_tick) begin
          if (cnt_q + 6'h01 >= deb_limit) begin
            gin_q[g] <= port_pins_i[g];
            cnt_q <= 6'h00;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
      end
    end
  endgenerate

  // fade ramp: 17 levels, 16 equal intervals
  // step_q runs 0 to 16; duty is the common level times step over 16
  pgc_fade_t fade_q;
  logic [4:0] step_q;
  logic [31:0] fcnt_q;
  logic [7:0] duty_q;
  wire logic [2:0] fcode = glob_q[`PGC_FADE_MSB:0];
  // codes 6 and 7 have no defined period, so they jump like code 0
  wire logic fade_none = (fcode == 3'h0) || (fcode > 3'h5); // undefined codes act as none
  // interval doubles with each code step
  wire logic [31:0] interval = 32'(FADE_UNIT_CYC) << (fcode - 3'h1);
  wire logic fstep = (fcnt_q >= interval - 32'h1);
  wire logic [12:0] prod = 13'(common_pwm_i) * 13'(step_q);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fade_q <= PGC_FADE_LOW;
      step_q <= 5'h00;
      fcnt_q <= 32'h0;
    end else if (!enabled) begin
      fcnt_q <= 32'h0; // pwm shut down, ramp frozen
    end else if (fade_none) begin
      step_q <= fade_on_i ? 5'h10 : 5'h00; // no fading: jump
      fade_q <= fade_on_i ? PGC_FADE_HIGH : PGC_FADE_LOW;
      fcnt_q <= 32'h0;
    end else begin
      case (fade_q)
        // idle at zero until asked to rise
        PGC_FADE_LOW: if (fade_on_i) begin
          fade_q <= PGC_FADE_RISE;
          fcnt_q <= 32'h0;
        end
        // held at full until asked to fall
        PGC_FADE_HIGH: if (!fade_on_i) begin
          fade_q <= PGC_FADE_FALL;
          fcnt_q <= 32'h0;
        end
        // ramping in either direction
        PGC_FADE_RISE, PGC_FADE_FALL: begin
          // a reversal restarts the interval but keeps the current step
          if (fade_on_i != (fade_q == PGC_FADE_RISE)) begin
            fade_q <= fade_on_i ? PGC_FADE_RISE : PGC_FADE_FALL; // reverse mid-ramp
            fcnt_q <= 32'h0;
          end else if (fstep) begin
            fcnt_q <= 32'h0;
            // end steps saturate, so a reversal at either end cannot wrap
            if (fade_q == PGC_FADE_RISE) begin
              step_q <= (step_q >= 5'h10) ? 5'h10 : step_q + 5'h01;
              if (step_q >= 5'h0f) fade_q <= PGC_FADE_HIGH;
            end else begin
              step_q <= (step_q == 5'h00) ? 5'h00 : step_q - 5'h01;
              if (step_q <= 5'h01) fade_q <= PGC_FADE_LOW;
            end
          end else begin
            fcnt_q <= fcnt_q + 32'h1;
          end
        end
        default: fade_q <= PGC_FADE_LOW;
      endcase
    end
  end

  // duty = common level scaled by step/16; zero while shut down
  // 255 times 16 fits in 12 bits, so bits 11:4 never overflow
  // forcing zero while off keeps a stale level away from the drivers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      duty_q <= 8'h00;
    end else begin
      duty_q <= enabled ? prod[11:4] : 8'h00;
    end
  end

  // every output comes straight from its flop
  assign rdata_o = rdata_q;
  assign port_interrupt_out_o = irq_q;
  assign upper_pin_pair_rotary_o = glob_q[`PGC_BIT_ROTARY];
  assign port_dir_o = dir_q;
  assign general_inputs_o = gin_q;
  assign drive_sel_o = drv_q[1:0];
  assign ports_shutdown_o = shut_q;
  assign device_shutdown_o = dev_shut_q;
  assign port_regs_reset_o = soft_rst_q;
  assign fade_duty_o = duty_q;

endmodule : pgc_global_cfg
`default_nettype wire

// File: src/pgc_params.svh
/*
  Constants for the port global configuration block: register offsets,
  field positions, power-on values and timing figures.
  Assumes a 250 MHz core clock and byte-wide internal register access.
*/
`ifndef PGC_PARAMS_SVH
`define PGC_PARAMS_SVH

// register offsets
`define PGC_OFF_GLOBAL 8'h40
`define PGC_OFF_DIR 8'h41
`define PGC_OFF_DEBOUNCE 8'h42
`define PGC_OFF_DRIVE 8'h43
`define PGC_OFF_TIMEOUT_FLAG 8'h48
`define PGC_OFF_PORT_LAST 8'h5f

// global configuration fields
`define PGC_BIT_ROTARY 7
`define PGC_BIT_TMO_IE 5
`define PGC_BIT_ENABLE 4
`define PGC_BIT_SOFT_RST 3
`define PGC_FADE_MSB 2

// sleep flag position in the key-switch config register
`define PGC_BIT_KEY_SLEEP 7

// power-on values
`define PGC_RST_GLOBAL 8'h00
`define PGC_RST_DIR 8'h00
`define PGC_RST_DEBOUNCE 5'h00
`define PGC_RST_DRIVE 8'hc0

// timing figures
`define PGC_CLK_KHZ 250000
`define PGC_DEB_BASE_MS 9
`define PGC_FADE_BASE_MS 256
`define PGC_FADE_STEPS 16

`endif

// File: src/pgc_pkg.sv
/*
  Types shared by the port global configuration block.
  Assumes pgc_params.svh carries all numeric constants.
*/
`default_nettype none
package pgc_pkg;
  // fade sequencer, one-hot
  typedef enum logic [3:0] {
    PGC_FADE_LOW = 4'h1,
    PGC_FADE_RISE = 4'h2,
    PGC_FADE_HIGH = 4'h4,
    PGC_FADE_FALL = 4'h8
  } pgc_fade_t;
endpackage : pgc_pkg
`default_nettype wire

// File: testbench/gpio_global_config_block_test.sv
/* top bench for pgc_global_cfg
   short ms and fade units keep the run brief */
`timescale 1ns/100ps
`default_nettype none
module gpio_global_config_block_test;
  logic clk = 1'b0, srst = 1'b1, tmo = 1'b0, slp = 1'b0, fon = 1'b0;
  logic wr, rd, irq, rot, psd, dsd, prr;
  logic [7:0] ad, wd, rdat, pwm = 8'h80, pins = 8'h00, dir, gin, duty, v;
  logic [1:0] drv;
  int n_mismatch = 0, total_checks = 0, n;
  always #2 clk = ~clk;
  pgc_host_model u_pgc_host_model (.clk_i(clk), .rdata_i(rdat), .wr_en_o(wr),
    .rd_en_o(rd), .addr_o(ad), .wdata_o(wd));
  pgc_global_cfg #(.MS_CYC(10), .FADE_UNIT_CYC(5)) u_pgc_global_cfg (.clk_i(clk),
    .srst_i(srst), .wr_en_i(wr), .rd_en_i(rd), .addr_i(ad), .wdata_i(wd),
    .rdata_o(rdat), .bus_timeout_i(tmo), .key_sleep_i(slp), .fade_on_i(fon),
    .common_pwm_i(pwm), .port_pins_i(pins), .port_interrupt_out_o(irq),
    .upper_pin_pair_rotary_o(rot), .port_dir_o(dir), .general_inputs_o(gin),
    .drive_sel_o(drv), .ports_shutdown_o(psd), .device_shutdown_o(dsd),
    .port_regs_reset_o(prr), .fade_duty_o(duty));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // write, then let it land
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_pgc_host_model.wr(a, d);
    repeat (2) @(posedge clk);
    #1;
  endtask : w
  task automatic g(input logic [7:0] a);
    u_pgc_host_model.rd(a, v);
  endtask : g
  // edges until duty (sel 0) or inputs (sel 1) reach e
  task automatic meas(input bit sel, input logic [7:0] e);
    n = 0;
    while ((sel ? gin : duty) !== e) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 2000) begin
        n_mismatch++;
        test_done();
      end
    end
  endtask : meas
  task automatic rng(input int lo, input int hi);
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask : rng
  task automatic t_por;
    for (int i = 0; i < 5; i++) begin
      g(8'h3f + 8'(i));
      chk(v, i == 4 ? 8'hc0 : 8'h00);
    end
    w(8'h41, 8'hff);
    g(8'h41);
    chk(v, 8'h00);
    @(posedge clk) slp <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({7'h00, dsd}, 8'h01);
    w(8'h40, 8'h10);
    chk({6'h00, dsd, psd}, 8'h00);
  endtask : t_por
  task automatic t_cfg;
    w(8'h40, 8'h90);
    chk({7'h00, rot}, 8'h01);
    w(8'h41, 8'ha5);
    chk(dir, 8'ha5);
    w(8'h42, 8'hff);
    g(8'h42);
    chk(v, 8'h1f);
    for (int i = 0; i < 4; i++) begin
      w(8'h43, 8'(i));
      chk({6'h00, drv}, 8'(i));
    end
    w(8'h40, 8'h98);
    chk(dir, 8'h00);
    g(8'h40);
    chk(v, 8'h00);
  endtask : t_cfg
  task automatic t_irq;
    for (int e = 1; e >= 0; e--) begin
      w(8'h40, e ? 8'h30 : 8'h10);
      @(posedge clk) tmo <= 1'b1;
      @(posedge clk) tmo <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({7'h00, irq}, 8'(e));
      g(8'h48);
      chk(v & 8'h01, 8'h01);
      @(posedge clk);
      #1 chk({7'h00, irq}, 8'h00);
      g(8'h48);
      chk(v, 8'h00);
    end
  endtask : t_irq
  task automatic t_time;
    for (int c = 0; c < 32; c += 31) begin
      w(8'h42, 8'(c));
      @(posedge clk) pins <= ~pins;
      meas(1'b1, ~pins);
      rng((8 + c) * 10, (9 + c) * 10 + 3);
    end
    for (int c = 0; c < 6; c++) begin
      w(8'h40, 8'h10 | 8'(c));
      @(posedge clk) fon <= 1'b1;
      meas(1'b0, pwm);
      rng(c ? 75 << (c - 1) : 0, c ? (80 << (c - 1)) + 3 : 3);
      @(posedge clk) fon <= 1'b0;
      meas(1'b0, 8'h00);
    end
  endtask : t_time
  // shut section: duty forced to zero, inputs frozen, resume on enable
  task automatic t_shut;
    w(8'h40, 8'h10);
    @(posedge clk) fon <= 1'b1;
    meas(1'b0, pwm);
    w(8'h40, 8'h00);
    chk(duty, 8'h00);
    chk({7'h00, psd}, 8'h01);
    @(posedge clk) pins <= 8'hff;
    repeat (450) @(posedge clk);
    #1 chk(gin, 8'h00);
    w(8'h40, 8'h10);
    meas(1'b1, 8'hff);
    rng(380, 403);
  endtask : t_shut
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_por();
    t_cfg();
    t_irq();
    t_time();
    t_shut();
    test_done();
  end
endmodule : gpio_global_config_block_test
`default_nettype wire

// File: testbench/pgc_global_cfg_properties.sv
/* port-level checker for pgc_global_cfg
   assumes one clock and a synchronous reset */
`timescale 1ns/100ps
`default_nettype none
module pgc_global_cfg_properties #(parameter int NPORT = 8) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic bus_timeout_i,
  input wire logic key_sleep_i,
  input wire logic port_interrupt_out_o,
  input wire logic upper_pin_pair_rotary_o,
  input wire logic [NPORT-1:0] port_dir_o,
  input wire logic ports_shutdown_o,
  input wire logic device_shutdown_o,
  input wire logic port_regs_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // global writes, plain and soft reset
  wire gw = wr_en_i && addr_i == 8'h40 && !wdata_i[3];
  wire sw = wr_en_i && addr_i == 8'h40 && wdata_i[3];
  // direction write; a write just before may still be landing
  wire dw = wr_en_i && addr_i == 8'h41;
  sequence s_pulse;
    port_regs_reset_o ##1 !port_regs_reset_o;
  endsequence
  rotary_bit_a: assert property (gw |=> upper_pin_pair_rotary_o == $past(wdata_i[7]))
    else $error("rotary bit");
  irq_clear_a: assert property (rd_en_i && addr_i == 8'h48 && !bus_timeout_i |=> !port_interrupt_out_o)
    else $error("irq clear");
  port_enable_a: assert property (gw |-> ##2 ports_shutdown_o == !$past(wdata_i[4], 2))
    else $error("enable");
  full_sleep_a: assert property (!$past(srst_i) |->
    device_shutdown_o == (ports_shutdown_o && $past(key_sleep_i)))
    else $error("sleep");
  dir_write_a: assert property (dw && !ports_shutdown_o && !$past(wr_en_i) |=> port_dir_o == $past(wdata_i))
    else $error("dir write");
  dir_freeze_a: assert property (dw && ports_shutdown_o && !$past(wr_en_i) |=> $stable(port_dir_o))
    else $error("dir freeze");
  soft_pulse_a: assert property (sw |=> s_pulse)
    else $error("soft pulse");
  soft_clear_a: assert property (sw |-> ##2 port_dir_o == '0 && !upper_pin_pair_rotary_o)
    else $error("soft clear");
endmodule : pgc_global_cfg_properties
bind pgc_global_cfg pgc_global_cfg_properties #(.NPORT(NPORT)) u_pgc_global_cfg_properties (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .bus_timeout_i(bus_timeout_i),
  .key_sleep_i(key_sleep_i),
  .port_interrupt_out_o(port_interrupt_out_o),
  .upper_pin_pair_rotary_o(upper_pin_pair_rotary_o),
  .port_dir_o(port_dir_o),
  .ports_shutdown_o(ports_shutdown_o),
  .device_shutdown_o(device_shutdown_o),
  .port_regs_reset_o(port_regs_reset_o)
);
`default_nettype wire

// File: testbench/pgc_host_model.sv
/* host side: byte write and read strobes
   assumes the block takes strobes on the rising edge */
`timescale 1ns/100ps
`default_nettype none
module pgc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_en_o = 1'b0,
  output logic rd_en_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00
);
  // released lines show the inverse, never the stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= (a == 8'h43) ? {6'h30, d[1:0]} : d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask : rd
endmodule : pgc_host_model
`default_nettype wire
